// ---- pie_pkg.sv ----
// Constants, register map and types of the peripheral interrupt enable bank
package pie_pkg;

    // ****************************************************************
    // Bus and register widths
    // ****************************************************************
    localparam int unsigned PIE_ADR_W = 8;
    localparam int unsigned PIE_DAT_W = 32;
    localparam int unsigned PIE_REG_W = 8;
    localparam int unsigned PIE_SEL_W = 4;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] PIE_ADR_ENABLE1 = 8'h00;
    localparam logic [7:0] PIE_ADR_MAIN_CTRL = 8'h04;
    localparam logic [7:0] PIE_ADR_FLAGS = 8'h08;
    localparam logic [7:0] PIE_ADR_FLAGS_CLR = 8'h0C;
    localparam logic [7:0] PIE_ADR_PIN_FLAGS = 8'h10;
    localparam logic [7:0] PIE_ADR_PIN_CLR = 8'h14;

    // ****************************************************************
    // Field positions of the enable and flag registers
    // ****************************************************************
    localparam int unsigned PIE_BIT_TMR_GATE = 7;
    localparam int unsigned PIE_BIT_CONV_DONE = 6;
    localparam int unsigned PIE_BIT_SER_RX = 5;
    localparam int unsigned PIE_BIT_SER_TX = 4;
    localparam int unsigned PIE_BIT_SYNC_PORT = 3;
    localparam int unsigned PIE_BIT_CAP_CMP = 2;
    localparam int unsigned PIE_BIT_PER_MATCH = 1;
    localparam int unsigned PIE_BIT_TMR_OVF = 0;

    // Field positions of the main interrupt control register
    localparam int unsigned PIE_BIT_GIE = 7;
    localparam int unsigned PIE_BIT_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
    localparam int unsigned PIE_BIT_SUMMARY = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] PIE_RST_ENABLE1 = 8'h00;
    localparam logic [7:0] PIE_RST_FLAGS = 8'h00;
    localparam logic [31:0] PIE_RD_ZERO = 32'h00000000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_irq_enable;
    } pie_ctrl_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] adr;
        logic [7:0] wdata;
    } pie_wb_req_t;

endpackage

// ---- pie_flag_bank.sv ----
// Sticky flag bank: hardware set wins over software clear
`timescale 1ns/1ps
module pie_flag_bank
    import pie_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);

    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;

    // Set term applied after clear so a same-cycle event survives
    always_comb begin
        nxt_flags = (flags_ff & ~clr_i) | set_i;
    end

    // Flag storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= W'(PIE_RST_FLAGS);
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_o = flags_ff;

endmodule

// ---- pie_irq_enable_bank.sv ----
// Peripheral interrupt enable bank with Wishbone register slave
//
// Function
// [R01] Pin-change summary flag is read-only, clears once all per-pin flags clear.
// [R02] Flags set on source events regardless of any enable bit.
// [R03] Software should clear a flag before setting its enable bit.
// [R04] Enable bit 7 gates the timer gate acquisition interrupt.
// [R05] Enable bit 6 gates the converter done interrupt.
// [R06] Enable bit 4 gates the serial transmit interrupt.
// [R07] Enable bit 3 gates the synchronous serial port interrupt.
// [R08] All eight enable bits read and write, reset to zero on any reset.
// [R09] No peripheral interrupt without the peripheral group enable set.
// [R10] Enable bit 5 gates the serial receive interrupt.
// [R11] Request raised when flag, its enable, group and global enables are set.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pie_irq_enable_bank
    import pie_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [PIE_ADR_W-1:0] wb_adr_i,
    input wire logic [PIE_SEL_W-1:0] wb_sel_i,
    input wire logic [PIE_DAT_W-1:0] wb_dat_i,
    output logic [PIE_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PIE_REG_W-1:0] periph_event_i,
    input wire logic [PIE_REG_W-1:0] pin_change_i,
    output logic irq_o,
    output logic pin_change_summary_flag_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic ack_ff;
    logic [PIE_DAT_W-1:0] rdata_ff;
    logic [PIE_DAT_W-1:0] nxt_rdata;
    logic [PIE_REG_W-1:0] peripheral_irq_enable_1_ff;
    pie_ctrl_t ctrl_ff;
    pie_wb_req_t req;
    logic [PIE_REG_W-1:0] periph_flags;
    logic [PIE_REG_W-1:0] per_pin_change_flags;
    logic [PIE_REG_W-1:0] periph_clr;
    logic [PIE_REG_W-1:0] pin_clr;
    logic [PIE_REG_W-1:0] pending;
    logic pin_change_summary_flag;
    logic [PIE_REG_W-1:0] main_ctrl_view;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************

    // Request decode; a write commits in the cycle ack is high
    always_comb begin
        req.rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
        req.wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
        req.adr = wb_adr_i;
        req.wdata = wb_dat_i[PIE_REG_W-1:0];
    end

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
        end
    end

    // Main control register view, unused bits read zero
    always_comb begin
        main_ctrl_view = '0;
        main_ctrl_view[PIE_BIT_GIE] = ctrl_ff.global_irq_enable;
        main_ctrl_view[PIE_BIT_PERIPHERAL_GROUP_IRQ_ENABLE] = ctrl_ff.peripheral_group_irq_enable;
        main_ctrl_view[PIE_BIT_SUMMARY] = pin_change_summary_flag;
    end

    // Read mux; clear registers and unmapped addresses read zero
    always_comb begin
        nxt_rdata = PIE_RD_ZERO;
        unique case (req.adr)
            PIE_ADR_ENABLE1: begin
                nxt_rdata[PIE_REG_W-1:0] = peripheral_irq_enable_1_ff; // R08
            end
            PIE_ADR_MAIN_CTRL: begin
                nxt_rdata[PIE_REG_W-1:0] = main_ctrl_view;
            end
            PIE_ADR_FLAGS: begin
                nxt_rdata[PIE_REG_W-1:0] = periph_flags;
            end
            PIE_ADR_PIN_FLAGS: begin
                nxt_rdata[PIE_REG_W-1:0] = per_pin_change_flags;
            end
            default: begin
                nxt_rdata = PIE_RD_ZERO;
            end
        endcase
    end

    // Read data captured as ack is raised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= PIE_RD_ZERO;
        end else if (req.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;

    // ****************************************************************
    // Software registers
    // ****************************************************************

    // Peripheral enable register, all bits read/write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peripheral_irq_enable_1_ff <= PIE_RST_ENABLE1; // R08
        end else if (req.wr && req.adr == PIE_ADR_ENABLE1) begin
            peripheral_irq_enable_1_ff <= req.wdata; // R08
        end
    end

    // Global and group enables; the summary bit ignores writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= '0;
        end else if (req.wr && req.adr == PIE_ADR_MAIN_CTRL) begin
            ctrl_ff.global_irq_enable <= req.wdata[PIE_BIT_GIE];
            ctrl_ff.peripheral_group_irq_enable <= req.wdata[PIE_BIT_PERIPHERAL_GROUP_IRQ_ENABLE];
        end
    end

    // Write-one-to-clear strobes for the two flag banks
    always_comb begin
        periph_clr = '0;
        pin_clr = '0;
        if (req.wr && req.adr == PIE_ADR_FLAGS_CLR) begin
            periph_clr = req.wdata;
        end
        if (req.wr && req.adr == PIE_ADR_PIN_CLR) begin
            pin_clr = req.wdata;
        end
    end

    // ****************************************************************
    // Flags and interrupt request
    // ****************************************************************

    // Peripheral flags latch on events, ignoring every enable
    pie_flag_bank #(
        .W(PIE_REG_W)
    ) u_periph_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(periph_event_i), // R02
        .clr_i(periph_clr),
        .flags_o(periph_flags)
    );

    // Per-pin change flags
    pie_flag_bank #(
        .W(PIE_REG_W)
    ) u_pin_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(pin_change_i), // R02
        .clr_i(pin_clr),
        .flags_o(per_pin_change_flags)
    );

    // Summary is derived, so it falls only when every pin flag is clear
    assign pin_change_summary_flag = |per_pin_change_flags; // R01
    assign pin_change_summary_flag_o = pin_change_summary_flag;

    // Per-source gating by the enable bits
    always_comb begin
        pending = periph_flags & peripheral_irq_enable_1_ff;
        pending[PIE_BIT_TMR_GATE] = periph_flags[PIE_BIT_TMR_GATE] &
            peripheral_irq_enable_1_ff[PIE_BIT_TMR_GATE]; // R04
        pending[PIE_BIT_CONV_DONE] = periph_flags[PIE_BIT_CONV_DONE] &
            peripheral_irq_enable_1_ff[PIE_BIT_CONV_DONE]; // R05
        pending[PIE_BIT_SER_RX] = periph_flags[PIE_BIT_SER_RX] &
            peripheral_irq_enable_1_ff[PIE_BIT_SER_RX]; // R10
        pending[PIE_BIT_SER_TX] = periph_flags[PIE_BIT_SER_TX] &
            peripheral_irq_enable_1_ff[PIE_BIT_SER_TX]; // R06
        pending[PIE_BIT_SYNC_PORT] = periph_flags[PIE_BIT_SYNC_PORT] &
            peripheral_irq_enable_1_ff[PIE_BIT_SYNC_PORT]; // R07
    end

    // Level request needs group and global enables as well
    assign irq_o = ctrl_ff.global_irq_enable &
        ctrl_ff.peripheral_group_irq_enable & (|pending); // R09 R11

    // ****************************************************************
    // Assertions
    // ****************************************************************

    // Summary is read-only: it falls only after a per-pin flag clear
    property p_summary_ro;
        @(posedge clk_i) disable iff (rst_i)
        ($fell(pin_change_summary_flag) && !$past(rst_i)) |->
            $past(|pin_clr);
    endproperty
    a_summary_ro: assert property (p_summary_ro) // R01
        else $error("summary flag does not follow pin flags");

    // Summary stays set while any pin flag remains after a clear
    property p_summary_hold;
        @(posedge clk_i) disable iff (rst_i)
        ((|pin_clr) && ((per_pin_change_flags & ~pin_clr) != 8'h00))
            |=> pin_change_summary_flag;
    endproperty
    a_summary_hold: assert property (p_summary_hold) // R01
        else $error("summary flag cleared while pin flags remain");

    // Any event is visible as a flag on the next cycle, even if cleared
    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        (|periph_event_i) |=>
            ((periph_flags & $past(periph_event_i)) ==
             $past(periph_event_i));
    endproperty
    a_flag_set: assert property (p_flag_set) // R02
        else $error("peripheral event did not set its flag");

    // Timer gate bit alone
    property p_en_tmr_gate;
        @(posedge clk_i) disable iff (rst_i)
        (periph_flags == 8'h80 && ctrl_ff == 2'h3) |->
            (irq_o == peripheral_irq_enable_1_ff[PIE_BIT_TMR_GATE]);
    endproperty
    a_en_tmr_gate: assert property (p_en_tmr_gate) // R04
        else $error("timer gate enable does not gate request");

    // Converter done bit alone
    property p_en_conv_done;
        @(posedge clk_i) disable iff (rst_i)
        (periph_flags == 8'h40 && ctrl_ff == 2'h3) |->
            (irq_o == peripheral_irq_enable_1_ff[PIE_BIT_CONV_DONE]);
    endproperty
    a_en_conv_done: assert property (p_en_conv_done) // R05
        else $error("converter enable does not gate request");

    // Serial receive bit alone
    property p_en_ser_rx;
        @(posedge clk_i) disable iff (rst_i)
        (periph_flags == 8'h20 && ctrl_ff == 2'h3) |->
            (irq_o == peripheral_irq_enable_1_ff[PIE_BIT_SER_RX]);
    endproperty
    a_en_ser_rx: assert property (p_en_ser_rx) // R10
        else $error("receive enable does not gate request");

    // Serial transmit bit alone
    property p_en_ser_tx;
        @(posedge clk_i) disable iff (rst_i)
        (periph_flags == 8'h10 && ctrl_ff == 2'h3) |->
            (irq_o == peripheral_irq_enable_1_ff[PIE_BIT_SER_TX]);
    endproperty
    a_en_ser_tx: assert property (p_en_ser_tx) // R06
        else $error("transmit enable does not gate request");

    // Synchronous port bit alone
    property p_en_sync_port;
        @(posedge clk_i) disable iff (rst_i)
        (periph_flags == 8'h08 && ctrl_ff == 2'h3) |->
            (irq_o == peripheral_irq_enable_1_ff[PIE_BIT_SYNC_PORT]);
    endproperty
    a_en_sync_port: assert property (p_en_sync_port) // R07
        else $error("sync port enable does not gate request");

    // Enable register is zero right after reset release
    property p_en_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (peripheral_irq_enable_1_ff == 8'h00);
    endproperty
    a_en_reset: assert property (p_en_reset) // R08
        else $error("enable register not zero after reset");

    // Acked write to the enable register stores the low byte
    property p_en_write;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
         wb_adr_i == PIE_ADR_ENABLE1) |=>
            (peripheral_irq_enable_1_ff == $past(wb_dat_i[7:0]));
    endproperty
    a_en_write: assert property (p_en_write) // R08
        else $error("enable register write lost");

    // Group enable low keeps the request low
    property p_group;
        @(posedge clk_i) disable iff (rst_i)
        !ctrl_ff.peripheral_group_irq_enable |-> !irq_o;
    endproperty
    a_group: assert property (p_group) // R09
        else $error("request raised without group enable");

    // Request equals the full enable chain over all sources
    property p_request;
        @(posedge clk_i) disable iff (rst_i)
        irq_o == (ctrl_ff.global_irq_enable &&
                  ctrl_ff.peripheral_group_irq_enable &&
                  ((periph_flags & peripheral_irq_enable_1_ff) != 8'h00));
    endproperty
    a_request: assert property (p_request) // R11
        else $error("request does not match flags and enables");

    // Ack answers one cycle after the strobe and lasts one cycle
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not one cycle after strobe");

    // Main scenarios
    c_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o));
    c_set_and_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        (|(periph_event_i & periph_clr)));
    c_summary_fall: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(pin_change_summary_flag));
    c_gated_flag: cover property (@(posedge clk_i) disable iff (rst_i)
        (periph_flags != 8'h00) && !irq_o);

endmodule

// ---- pie_core_model.sv ----
// Core-side model: Wishbone master of the core
`timescale 1ns/1ps
module pie_core_model
    import pie_pkg::*;
(
    input wire logic clk_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [PIE_ADR_W-1:0] wb_adr_o,
    output logic [PIE_SEL_W-1:0] wb_sel_o,
    output logic [PIE_DAT_W-1:0] wb_dat_o,
    input wire logic [PIE_DAT_W-1:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // ****************************************************************
    // Bus master state
    // ****************************************************************
    int timeouts = 0;

    // Idle bus at time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
    end

    // ****************************************************************
    // Single classic cycle, held until ack is seen at a rising edge
    // ****************************************************************
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'h1;
        wb_dat_o <= {24'h000000, wd};
        // Ack and read data are taken at the rising edge, as flops see them
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 50);
        if (wb_ack_i !== 1'b1) begin
            timeouts++;
        end
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        wb_sel_o <= 4'h0;
        wb_dat_o <= 32'hFFFFFFFF; // Released data shows no stale value
    endtask
endmodule

// ---- pie_irq_enable_bank_bench.sv ----
// Self-checking bench of the peripheral interrupt enable bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    mismatches++; $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
    end end
module pie_irq_enable_bank_bench
    import pie_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, summary;
    logic [PIE_ADR_W-1:0] wb_adr;
    logic [PIE_SEL_W-1:0] wb_sel;
    logic [PIE_DAT_W-1:0] wb_wdat, wb_rdat;
    logic [7:0] ev = 8'h00;
    logic [7:0] pin = 8'h00;
    logic [7:0] m;
    int mismatches = 0;
    int n_checks = 0;

    // Clock of 100 ns period
    always #50 clk_i = ~clk_i;

    // ****************************************************************
    // Instances
    // ****************************************************************
    pie_core_model core_u (
        .clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
        .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack)
    );

    pie_irq_enable_bank dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .periph_event_i(ev), .pin_change_i(pin), .irq_o(irq),
        .pin_change_summary_flag_o(summary)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        core_u.access(1'b1, a, d, x);
        if (core_u.timeouts != 0) begin
            finish_test();
        end
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        core_u.access(1'b0, a, 8'h00, x);
        if (core_u.timeouts != 0) begin
            finish_test();
        end
        `CHK(nm, exp, x)
    endtask

    // Outputs are compared mid-cycle, after the edge's updates land
    task automatic chk_out(input string nm, input logic got_sel,
                           input logic exp);
        @(negedge clk_i);
        if (got_sel) begin
            `CHK(nm, exp, summary)
        end else begin
            `CHK(nm, exp, irq)
        end
    endtask

    // One-cycle event pulse on the source and pin-change inputs
    task automatic pulse(input logic [7:0] pe, input logic [7:0] pc);
        @(posedge clk_i);
        ev <= pe;
        pin <= pc;
        @(posedge clk_i);
        ev <= 8'h00;
        pin <= 8'h00;
    endtask

    task automatic finish_test();
        mismatches += core_u.timeouts;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("enable1_rst", PIE_ADR_ENABLE1, 32'h00000000);
        rd_chk("main_rst", PIE_ADR_MAIN_CTRL, 32'h00000000);
        wr(PIE_ADR_ENABLE1, 8'hFF);
        rd_chk("enable1_ff", PIE_ADR_ENABLE1, 32'h000000FF);
        wr(PIE_ADR_ENABLE1, 8'h5A);
        rd_chk("enable1_5a", PIE_ADR_ENABLE1, 32'h0000005A);
        // Reset in mid-run clears the enable register again
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("enable1_rst2", PIE_ADR_ENABLE1, 32'h00000000);
        // Flags latch with every enable off
        pulse(8'hFF, 8'h00);
        chk_out("irq_off", 1'b0, 1'b0);
        rd_chk("flags_all", PIE_ADR_FLAGS, 32'h000000FF);
        // An event in the cycle of its clear keeps the flag set
        ev <= 8'h01;
        wr(PIE_ADR_FLAGS_CLR, 8'h01);
        ev <= 8'h00;
        rd_chk("set_wins", PIE_ADR_FLAGS, 32'h000000FF);
        wr(PIE_ADR_MAIN_CTRL, 8'hC0);
        // Each enable bit passes only its own source
        for (int k = 0; k < 8; k++) begin
            m = 8'h01 << k;
            wr(PIE_ADR_FLAGS_CLR, 8'hFF);
            rd_chk("flags_clr", PIE_ADR_FLAGS, 32'h00000000);
            wr(PIE_ADR_ENABLE1, m);
            pulse(~m, 8'h00);
            chk_out("irq_other", 1'b0, 1'b0);
            pulse(m, 8'h00);
            chk_out("irq_own", 1'b0, 1'b1);
        end
        // Group and global enables both needed
        wr(PIE_ADR_MAIN_CTRL, 8'h80);
        chk_out("irq_no_group", 1'b0, 1'b0);
        wr(PIE_ADR_MAIN_CTRL, 8'h40);
        chk_out("irq_no_global", 1'b0, 1'b0);
        wr(PIE_ADR_MAIN_CTRL, 8'hC0);
        chk_out("irq_all", 1'b0, 1'b1);
        wr(PIE_ADR_FLAGS_CLR, 8'h80);
        chk_out("irq_cleared", 1'b0, 1'b0);
        wr(PIE_ADR_MAIN_CTRL, 8'h00);
        // Summary flag is read-only and follows the per-pin flags
        pulse(8'h00, 8'h05);
        chk_out("summary_set", 1'b1, 1'b1);
        wr(PIE_ADR_MAIN_CTRL, 8'h00);
        rd_chk("main_summary", PIE_ADR_MAIN_CTRL, 32'h00000001);
        wr(PIE_ADR_PIN_CLR, 8'h01);
        rd_chk("pin_flags", PIE_ADR_PIN_FLAGS, 32'h00000004);
        chk_out("summary_held", 1'b1, 1'b1);
        wr(PIE_ADR_PIN_CLR, 8'h04);
        chk_out("summary_clr", 1'b1, 1'b0);
        rd_chk("main_clr", PIE_ADR_MAIN_CTRL, 32'h00000000);
        // Unmapped and write-only places read as zero
        wr(8'h20, 8'hAA);
        rd_chk("unmapped", 8'h20, 32'h00000000);
        rd_chk("clr_reads_0", PIE_ADR_FLAGS_CLR, 32'h00000000);
        finish_test();
    end
endmodule
